// [tic_core_model.sv]
`timescale 1ns/100ps
module tic_core_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // device handshake
    input  wire logic        intReq,
    input  wire logic [15:0] intVector,
    output logic             intAck,
    output logic             intReturn,
    // bench control and status
    input  wire logic [3:0]  ackDelay,
    input  wire logic        retCmd,
    output logic      [15:0] lastVec,
    output logic      [7:0]  depth
);
    // ----------------------------------------
    // call on accept, return on command
    // ----------------------------------------
    logic [3:0] waitCnt_ff;

    // call counted only at the edge where accept meets a standing request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            intAck     <= 1'b0;
            intReturn  <= 1'b0;
            lastVec    <= 16'h0000;
            depth      <= 8'h00;
            waitCnt_ff <= 4'h0;
        end else begin
            intAck     <= 1'b0;
            intReturn  <= 1'b0;
            waitCnt_ff <= (intReq && !intAck && waitCnt_ff != 4'hf) ?
                          waitCnt_ff + 4'h1 : 4'h0;
            if (intReq && !intAck && waitCnt_ff >= ackDelay) begin
                intAck     <= 1'b1;
                waitCnt_ff <= 4'h0;
            end
            if (intAck && intReq) begin
                lastVec <= intVector;
                depth   <= depth + 8'h01;
            end else if (retCmd && depth != 8'h00) begin
                intReturn <= 1'b1;
                depth     <= depth - 8'h01;
            end
        end
    end
endmodule // tic_core_model

// [tic_pkg.sv]
package tic_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL  = 3'h0;
    localparam logic [2:0] ADDR_IEN   = 3'h1;
    localparam logic [2:0] ADDR_IPRI  = 3'h2;
    localparam logic [2:0] ADDR_MODE  = 3'h3;
    localparam logic [2:0] ADDR_T0LO  = 3'h4;
    localparam logic [2:0] ADDR_T0HI  = 3'h5;
    localparam logic [2:0] ADDR_T1LO  = 3'h6;
    localparam logic [2:0] ADDR_T1HI  = 3'h7;
    // control register bit positions
    localparam int CTL_TOV1 = 7;
    localparam int CTL_RUN1 = 6;
    localparam int CTL_TOV0 = 5;
    localparam int CTL_RUN0 = 4;
    localparam int CTL_PRQ1 = 3;
    localparam int CTL_TRG1 = 2;
    localparam int CTL_PRQ0 = 1;
    localparam int CTL_TRG0 = 0;
    // enable register
    localparam int IEN_GLOBAL = 7;
    localparam logic [7:0] IEN_MASK  = 8'h9f;
    localparam logic [7:0] IPRI_MASK = 8'h1f;
    // mode register: per timer nibble, bit3 gate, bit2 source select
    localparam int MODE_GATE = 3;
    localparam int MODE_SRC  = 2;
    localparam int MODE_T1_BASE = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // sources: 0 pin0, 1 timer0, 2 pin1, 3 timer1, 4 serial
    localparam int NUM_SRC = 5;
    localparam int SRC_PIN0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_PIN1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_SER  = 4;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    // instruction cycle: 12 core clocks (1 us at 12 MHz); cycles per tick
    localparam int CYC_PER_TICK = 12;
    localparam logic [3:0] TICK_LAST = 4'(CYC_PER_TICK - 1);
endpackage

// [tic_unit.sv]
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
// Contract
// - five sources: serial, two timers, two pins
// - per-source enable, flags still pollable
// - high priority preempts low routine
// - fixed vectors eight bytes apart from 0003h
// - accepted request forces call, return resumes
// - global enable bit blocks all interrupts
// - serial enable gates transmit or receive done
// - enable bits 3..0 for timer/pin sources
// - priority bits 4..0 select high priority
// - overflow flags set by hardware, cleared serviced
// - run bits start and stop timers
// - pin flags set on trigger, cleared serviced
// - trigger type: edge when set, level cleared
// - gate bit needs pin high to count
// - source select: internal or external pin
// - two sixteen-bit timers, high and low bytes
// - timer counts instruction cycles, full range
// - counter counts external transitions, sixteen bits
// - overflow and serial flags readable by software; only the overflow flags are on the read port, serial flags are not
module tic_unit (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [2:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    // pins
    input  wire logic        irqPin0,
    input  wire logic        irqPin1,
    input  wire logic        countPin0,
    input  wire logic        countPin1,
    // serial port flags
    input  wire logic        transmitDoneFlag,
    input  wire logic        receiveDoneFlag,
    // core handshake
    output logic             intReq,
    output logic      [15:0] intVector,
    input  wire logic        intAck,
    input  wire logic        intReturn
);
    localparam int N = tic_pkg::NUM_SRC;

    logic [7:0]   ctrl_ff;
    logic [7:0]   ien_ff;
    logic [7:0]   ipri_ff;
    logic [7:0]   mode_ff;
    logic [15:0]  tmr_ff [2];
    logic [1:0]   pinS1_ff;
    logic [1:0]   pinS2_ff;
    logic [1:0]   pinOld_ff;
    logic [1:0]   cntS1_ff;
    logic [1:0]   cntS2_ff;
    logic [1:0]   cntOld_ff;
    logic [3:0]   tick_ff;
    logic [1:0]   actLvl_ff;   // bit1 high routine active, bit0 low
    logic [2:0]   curSrc_ff;
    logic [N-1:0] pend;
    logic [N-1:0] enab;
    logic [N-1:0] hiSel;
    logic [1:0]   ovf;
    logic [1:0]   pinFall;
    logic [1:0]   cntFall;
    logic [1:0]   runOk;
    logic [1:0]   inc;
    logic         ackHi;
    logic [2:0]   pick;
    logic         found;

    // ------------------------------------------------------------
    // synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinS1_ff  <= 2'h3;
            pinS2_ff  <= 2'h3;
            pinOld_ff <= 2'h3;
            cntS1_ff  <= 2'h0;
            cntS2_ff  <= 2'h0;
            cntOld_ff <= 2'h0;
        end else begin
            pinS1_ff  <= {irqPin1, irqPin0};
            pinS2_ff  <= pinS1_ff;
            pinOld_ff <= pinS2_ff;
            cntS1_ff  <= {countPin1, countPin0};
            cntS2_ff  <= cntS1_ff;
            cntOld_ff <= cntS2_ff;
        end
    end
    assign pinFall = pinOld_ff & ~pinS2_ff;
    assign cntFall = cntOld_ff & ~cntS2_ff;

    // ------------------------------------------------------------
    // instruction-cycle prescaler
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            tick_ff <= 4'h0;
        else if (tick_ff == tic_pkg::TICK_LAST)
            tick_ff <= 4'h0;
        else
            tick_ff <= tick_ff + 4'h1;
    end

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gTmr
            localparam int MB = g * tic_pkg::MODE_T1_BASE;
            localparam int RB = g ? tic_pkg::CTL_RUN1 : tic_pkg::CTL_RUN0;
            localparam logic [2:0] LO = g ? tic_pkg::ADDR_T1LO : tic_pkg::ADDR_T0LO;
            localparam logic [2:0] HI = g ? tic_pkg::ADDR_T1HI : tic_pkg::ADDR_T0HI;
            assign runOk[g] = ctrl_ff[RB] &
                (!mode_ff[MB + tic_pkg::MODE_GATE] | pinS2_ff[g]);
            assign inc[g] = runOk[g] & (mode_ff[MB + tic_pkg::MODE_SRC] ?
                cntFall[g] : (tick_ff == tic_pkg::TICK_LAST));
            assign ovf[g] = inc[g] & (tmr_ff[g] == 16'hffff);
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b)
                    tmr_ff[g] <= 16'h0000;
                else if (regWrite && regAddr == LO)
                    tmr_ff[g][7:0] <= regWrData;
                else if (regWrite && regAddr == HI)
                    tmr_ff[g][15:8] <= regWrData;
                else if (inc[g])
                    tmr_ff[g] <= tmr_ff[g] + 16'h0001;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // request sources and arbitration
    // ------------------------------------------------------------
    assign pend = {transmitDoneFlag | receiveDoneFlag, ctrl_ff[tic_pkg::CTL_TOV1],
                   ctrl_ff[tic_pkg::CTL_PRQ1], ctrl_ff[tic_pkg::CTL_TOV0],
                   ctrl_ff[tic_pkg::CTL_PRQ0]};
    assign enab = pend & ien_ff[N-1:0] & {N{ien_ff[tic_pkg::IEN_GLOBAL]}};
    assign hiSel = enab & ipri_ff[N-1:0];

    function automatic logic [3:0] first_set(input logic [N-1:0] v);
        first_set = 4'h0;
        for (int i = N - 1; i >= 0; i--)
            if (v[i])
                first_set = {1'b1, 3'(i)};
    endfunction

    function automatic logic [N-1:0] below_mask(input logic [2:0] s);
        below_mask = '0;
        for (int i = 0; i < N; i++)
            below_mask[i] = (3'(i) < s);
    endfunction

    always_comb begin
        logic [3:0] h, l;
        h = first_set(hiSel);
        l = first_set(enab & ~ipri_ff[N-1:0]);
        found = 1'b0;
        pick  = 3'h0;
        ackHi = 1'b0;
        if (h[3] && !actLvl_ff[1]) begin
            found = 1'b1;
            pick  = h[2:0];
            ackHi = 1'b1;
        end else if (l[3] && actLvl_ff == 2'h0) begin
            found = 1'b1;
            pick  = l[2:0];
        end
    end

    // ------------------------------------------------------------
    // core handshake and in-service levels
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            intReq    <= 1'b0;
            intVector <= 16'h0000;
            curSrc_ff <= 3'h0;
        end else begin
            intReq <= found && !(intAck && intReq);
            curSrc_ff <= pick;
            intVector <= tic_pkg::VEC_BASE + tic_pkg::VEC_STEP * 16'(pick);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            actLvl_ff <= 2'h0;
        else if (intAck && intReq)
            actLvl_ff <= ipri_ff[curSrc_ff] ? (actLvl_ff | 2'h2) : 2'h1;
        else if (intReturn)
            actLvl_ff <= actLvl_ff[1] ? {1'b0, actLvl_ff[0]} : 2'h0;
    end

    // ------------------------------------------------------------
    // control/status register
    // ------------------------------------------------------------
    logic svc0;
    logic svc1;
    logic svcT0;
    logic svcT1;
    logic setP0;
    logic setP1;
    assign svc0  = intAck && intReq && curSrc_ff == 3'(tic_pkg::SRC_PIN0);
    assign svc1  = intAck && intReq && curSrc_ff == 3'(tic_pkg::SRC_PIN1);
    assign svcT0 = intAck && intReq && curSrc_ff == 3'(tic_pkg::SRC_TMR0);
    assign svcT1 = intAck && intReq && curSrc_ff == 3'(tic_pkg::SRC_TMR1);
    assign setP0 = ctrl_ff[tic_pkg::CTL_TRG0] ? pinFall[0] : !pinS2_ff[0];
    assign setP1 = ctrl_ff[tic_pkg::CTL_TRG1] ? pinFall[1] : !pinS2_ff[1];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            ctrl_ff <= tic_pkg::RESET_BYTE;
        else begin
            if (regWrite && regAddr == tic_pkg::ADDR_CTRL)
                ctrl_ff <= regWrData;
            else begin
                if (svcT1) ctrl_ff[tic_pkg::CTL_TOV1] <= 1'b0;
                if (svcT0) ctrl_ff[tic_pkg::CTL_TOV0] <= 1'b0;
                if (svc1)  ctrl_ff[tic_pkg::CTL_PRQ1] <= 1'b0;
                if (svc0)  ctrl_ff[tic_pkg::CTL_PRQ0] <= 1'b0;
            end
            // hardware set wins over any clear
            if (ovf[1]) ctrl_ff[tic_pkg::CTL_TOV1] <= 1'b1;
            if (ovf[0]) ctrl_ff[tic_pkg::CTL_TOV0] <= 1'b1;
            if (setP1)  ctrl_ff[tic_pkg::CTL_PRQ1] <= 1'b1;
            if (setP0)  ctrl_ff[tic_pkg::CTL_PRQ0] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // other registers and read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ien_ff  <= tic_pkg::RESET_BYTE;
            ipri_ff <= tic_pkg::RESET_BYTE;
            mode_ff <= tic_pkg::RESET_BYTE;
        end else if (regWrite) begin
            if (regAddr == tic_pkg::ADDR_IEN)  ien_ff  <= regWrData & tic_pkg::IEN_MASK;
            if (regAddr == tic_pkg::ADDR_IPRI) ipri_ff <= regWrData & tic_pkg::IPRI_MASK;
            if (regAddr == tic_pkg::ADDR_MODE) mode_ff <= regWrData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            regRdData <= 8'h00;
        else if (regRead) begin
            case (regAddr)
                tic_pkg::ADDR_CTRL: regRdData <= ctrl_ff;
                tic_pkg::ADDR_IEN:  regRdData <= ien_ff;
                tic_pkg::ADDR_IPRI: regRdData <= ipri_ff;
                tic_pkg::ADDR_MODE: regRdData <= mode_ff;
                tic_pkg::ADDR_T0LO: regRdData <= tmr_ff[0][7:0];
                tic_pkg::ADDR_T0HI: regRdData <= tmr_ff[0][15:8];
                tic_pkg::ADDR_T1LO: regRdData <= tmr_ff[1][7:0];
                default:            regRdData <= tmr_ff[1][15:8];
            endcase
        end else
            regRdData <= 8'h00;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_global_off;
        @(posedge core_clk) disable iff (!rst_b)
        !ien_ff[tic_pkg::IEN_GLOBAL] |=> !intReq;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request while disabled");

    property p_vec;
        @(posedge core_clk) disable iff (!rst_b)
        intReq |-> intVector == {10'h000, curSrc_ff, tic_pkg::VEC_BASE[2:0]};
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");

    property p_ovf_flag;
        @(posedge core_clk) disable iff (!rst_b)
        ovf[0] |=> ctrl_ff[tic_pkg::CTL_TOV0];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_no_nest_low;
        @(posedge core_clk) disable iff (!rst_b)
        (actLvl_ff[1] || (actLvl_ff[0] && hiSel == '0)) |=> !intReq;
    endproperty
    a_no_nest_low: assert property (p_no_nest_low) else $error("low request preempted");

    property p_hold_stop;
        @(posedge core_clk) disable iff (!rst_b)
        !ctrl_ff[tic_pkg::CTL_RUN0] && !regWrite |=> tmr_ff[0] == $past(tmr_ff[0]);
    endproperty
    a_hold_stop: assert property (p_hold_stop) else $error("timer ran while off");

    property p_order;
        @(posedge core_clk) disable iff (!rst_b)
        found |-> enab[pick] &&
            ((ackHi ? hiSel : enab & ~ipri_ff[N-1:0]) & below_mask(pick)) == '0;
    endproperty
    a_order: assert property (p_order) else $error("later source chosen first");

    property p_take_drop;
        @(posedge core_clk) disable iff (!rst_b)
        intAck && intReq |=> !intReq;
    endproperty
    a_take_drop: assert property (p_take_drop) else $error("request stood after accept");

    property p_tov_clear;
        @(posedge core_clk) disable iff (!rst_b)
        intAck && intReq && curSrc_ff == 3'(tic_pkg::SRC_TMR0) && !ovf[0] &&
            !(regWrite && regAddr == tic_pkg::ADDR_CTRL) |=> !ctrl_ff[tic_pkg::CTL_TOV0];
    endproperty
    a_tov_clear: assert property (p_tov_clear) else $error("overflow flag kept");

    property p_preempt;
        @(posedge core_clk) disable iff (!rst_b)
        actLvl_ff == 2'h1 && hiSel != '0 && !(intAck && intReq) |=> intReq;
    endproperty
    a_preempt: assert property (p_preempt) else $error("high request not raised");

    property p_pin_edge;
        @(posedge core_clk) disable iff (!rst_b)
        ctrl_ff[tic_pkg::CTL_TRG0] && pinFall[0] |=> ctrl_ff[tic_pkg::CTL_PRQ0];
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("pin edge flag not set");

    property p_gate_hold;
        @(posedge core_clk) disable iff (!rst_b)
        mode_ff[tic_pkg::MODE_GATE] && !pinS2_ff[0] && !regWrite |=>
            tmr_ff[0] == $past(tmr_ff[0]);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated timer ran");

    c_high_nest: cover property (@(posedge core_clk) actLvl_ff == 2'h3);
    c_pin_svc: cover property (@(posedge core_clk) svc0);
    c_tmr_ovf: cover property (@(posedge core_clk) ovf[1]);
    c_gate_hold: cover property (@(posedge core_clk) ctrl_ff[tic_pkg::CTL_RUN0] && !runOk[0]);
endmodule // tic_unit

// [tic_unit_tb_top.sv]
`timescale 1ns/100ps
module tic_unit_tb_top;
    logic        core_clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic        irqPin0 = 1'b1, irqPin1 = 1'b1, countPin0 = 1'b1, txDone = 1'b0, rxDone = 1'b0;
    logic        retCmd = 1'b0, intReq, intAck, intReturn;
    logic [2:0]  regAddr = 3'h0;
    logic [7:0]  regWrData = 8'h00, regRdData, depth;
    logic [15:0] intVector, lastVec;
    logic [3:0]  ackDelay = 4'h2;
    int          failures = 0, samples_checked = 0;

    always #12.5 core_clk = ~core_clk;

    tic_unit i_tic_unit (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .irqPin0(irqPin0), .irqPin1(irqPin1), .countPin0(countPin0), .countPin1(1'b1),
        .transmitDoneFlag(txDone), .receiveDoneFlag(rxDone), .intReq(intReq),
        .intVector(intVector), .intAck(intAck), .intReturn(intReturn));
    tic_core_model i_tic_core_model (.core_clk(core_clk), .rst_b(rst_b), .intReq(intReq),
        .intVector(intVector), .intAck(intAck), .intReturn(intReturn), .ackDelay(ackDelay),
        .retCmd(retCmd), .lastVec(lastVec), .depth(depth));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        chk(nm, {16'h0000, exp}, {16'h0000, regRdData});
        @(posedge core_clk);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task took(input logic [7:0] d, input logic [15:0] v, input string nm);
        for (int k = 0; k < 300 && depth !== d; k++) @(posedge core_clk);
        chk(nm, {d, v}, {depth, lastVec});
    endtask
    task noReq(input int n, input string nm);
        logic q;
        q = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            q = q | intReq;
        end
        chk(nm, 24'h0, {23'h0, q});
        @(posedge core_clk);
    endtask
    task ret;
        retCmd <= 1'b1;
        @(posedge core_clk);
        retCmd <= 1'b0;
        @(posedge core_clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(25 * 20000);
        failures++;
        final_report;
    end

    initial begin
        cyc(20);
        rst_b <= 1'b1;
        cyc(1);
        rd(tic_pkg::ADDR_CTRL, 8'h00, "ctrlRst");
        rd(tic_pkg::ADDR_IEN, 8'h00, "ienRst");
        wr(tic_pkg::ADDR_IEN, 8'hff);
        rd(tic_pkg::ADDR_IEN, 8'h9f, "ienMask");
        wr(tic_pkg::ADDR_IPRI, 8'hff);
        rd(tic_pkg::ADDR_IPRI, 8'h1f, "ipriMask");
        wr(tic_pkg::ADDR_IPRI, 8'h00);
        $display("registers done");
        wr(tic_pkg::ADDR_CTRL, 8'h01);
        wr(tic_pkg::ADDR_IEN, 8'h11);
        irqPin0 <= 1'b0;
        txDone <= 1'b1;
        noReq(20, "globalOff");
        wr(tic_pkg::ADDR_IEN, 8'h91);
        took(8'h01, 16'h0003, "sameLevelOrder");
        noReq(20, "heldSame");
        ret;
        took(8'h01, 16'h0023, "serialVec");
        txDone <= 1'b0;
        irqPin0 <= 1'b1;
        ret;
        $display("ordering done");
        wr(tic_pkg::ADDR_IPRI, 8'h10);
        cyc(4);
        irqPin0 <= 1'b0;
        took(8'h01, 16'h0003, "lowEntry");
        rxDone <= 1'b1;
        took(8'h02, 16'h0023, "preempt");
        rxDone <= 1'b0;
        irqPin0 <= 1'b1;
        cyc(4);
        irqPin0 <= 1'b0;
        noReq(20, "heldLow");
        ret;
        noReq(20, "heldEqual");
        ret;
        took(8'h01, 16'h0003, "resume");
        irqPin0 <= 1'b1;
        ret;
        wr(tic_pkg::ADDR_CTRL, 8'h00);
        wr(tic_pkg::ADDR_IPRI, 8'h00);
        irqPin0 <= 1'b0;
        took(8'h01, 16'h0003, "levelEntry");
        ret;
        took(8'h01, 16'h0003, "levelAgain");
        irqPin0 <= 1'b1;
        cyc(4);
        wr(tic_pkg::ADDR_CTRL, 8'h00);
        ret;
        $display("priority done");
        ackDelay <= 4'h6;
        wr(tic_pkg::ADDR_IEN, 8'h82);
        wr(tic_pkg::ADDR_T0LO, 8'hff);
        wr(tic_pkg::ADDR_T0HI, 8'hff);
        wr(tic_pkg::ADDR_CTRL, 8'h10);
        took(8'h01, 16'h000b, "timerVec");
        rd(tic_pkg::ADDR_CTRL, 8'h10, "ovfCleared");
        ret;
        wr(tic_pkg::ADDR_CTRL, 8'h00);
        wr(tic_pkg::ADDR_IEN, 8'h00);
        wr(tic_pkg::ADDR_T0LO, 8'hfe);
        wr(tic_pkg::ADDR_T0HI, 8'hff);
        wr(tic_pkg::ADDR_CTRL, 8'h10);
        cyc(9);
        rd(tic_pkg::ADDR_CTRL, 8'h10, "notYet");
        cyc(20);
        rd(tic_pkg::ADDR_CTRL, 8'h30, "pollFlag");
        chk("quietReq", 24'h0, {23'h0, intReq});
        wr(tic_pkg::ADDR_CTRL, 8'h04);
        irqPin1 <= 1'b0;
        cyc(5);
        rd(tic_pkg::ADDR_CTRL, 8'h0c, "pin1Edge");
        irqPin1 <= 1'b1;
        wr(tic_pkg::ADDR_CTRL, 8'h00);
        wr(tic_pkg::ADDR_MODE, 8'h04);
        wr(tic_pkg::ADDR_T0LO, 8'h00);
        wr(tic_pkg::ADDR_T0HI, 8'h00);
        wr(tic_pkg::ADDR_CTRL, 8'h10);
        repeat (5) begin
            countPin0 <= 1'b0;
            cyc(4);
            countPin0 <= 1'b1;
            cyc(4);
        end
        wr(tic_pkg::ADDR_CTRL, 8'h00);
        rd(tic_pkg::ADDR_T0LO, 8'h05, "countEvents");
        wr(tic_pkg::ADDR_MODE, 8'h08);
        wr(tic_pkg::ADDR_T0LO, 8'h00);
        irqPin0 <= 1'b0;
        wr(tic_pkg::ADDR_CTRL, 8'h10);
        cyc(40);
        rd(tic_pkg::ADDR_T0LO, 8'h00, "gatedStill");
        irqPin0 <= 1'b1;
        cyc(38);
        rd(tic_pkg::ADDR_T0LO, 8'h03, "gatedRun");
        $display("timers done");
        final_report;
    end
endmodule // tic_unit_tb_top
